// [src/rtcv_top.sv]
// Timer and alarm BCD value registers behind pointer-selected windows
module rtcv_top
    import rtcv_pkg::*;
(
    input  wire logic        CLK_SYS_IN,            // 40 MHz system clock
    input  wire logic        RST_IN,                // Async reset, high
    input  wire logic        CE_IN,                 // Clock enable
    input  wire logic        WR_UNLOCK_IN,          // Timer and alarm write unlock level
    input  wire logic [2:0]  ACC_SEL_IN,            // Register select
    input  wire logic        ACC_RD_IN,             // Read strobe
    input  wire logic        ACC_WR_IN,             // Write strobe
    input  wire logic [7:0]  ACC_WDATA_IN,          // Write data
    output logic      [7:0]  ACC_RDATA_OUT,         // Read data, registered
    output logic      [1:0]  TIMER_PTR_OUT,         // Timer value pointer
    output logic      [1:0]  ALARM_PTR_OUT,         // Alarm value pointer
    output rtcv_time_s       TIME_VALUE_OUT,        // Timer values
    output rtcv_alarm_s      ALARM_VALUE_OUT        // Alarm compare values
);

    ////////////////////////////////////////////////////////////////////////
    // Access decode
    logic       acc_rd;                             // Read taken this cycle
    logic       acc_wr;                             // Write taken this cycle
    logic       hit_th;                             // Timer high selected
    logic       hit_tl;                             // Timer low selected
    logic       hit_ah;                             // Alarm high selected
    logic       hit_al;                             // Alarm low selected
    logic       wr_ok;                              // Write passes the lock
    logic [1:0] timer_value_pointer_r;              // Timer pointer
    logic [1:0] timer_value_pointer_nxt;            // Its next value
    logic [1:0] alarm_value_pointer_r;              // Alarm pointer
    logic [1:0] alarm_value_pointer_nxt;            // Its next value
    logic [7:0] rdata_nxt;                          // Read mux output
    logic       we_weekday;                         // Write enables
    logic       we_hour;
    logic       we_minute;
    logic       we_second;
    logic       we_amonth;
    logic       we_aday;
    logic       we_awd;
    logic       we_ahr;

    // Strobes count only while the clock enable is high
    assign acc_rd = CE_IN && ACC_RD_IN;
    assign acc_wr = CE_IN && ACC_WR_IN;
    assign hit_th = (ACC_SEL_IN == SEL_TIMER_HIGH);
    assign hit_tl = (ACC_SEL_IN == SEL_TIMER_LOW);
    assign hit_ah = (ACC_SEL_IN == SEL_ALARM_HIGH);
    assign hit_al = (ACC_SEL_IN == SEL_ALARM_LOW);
    assign wr_ok  = acc_wr && WR_UNLOCK_IN;

    ////////////////////////////////////////////////////////////////////////
    // Write enables per value register
    // Timer windows decode on the timer pointer
    assign we_weekday = wr_ok && hit_th && (timer_value_pointer_r == PTR_WD_HR);
    assign we_hour    = wr_ok && hit_tl && (timer_value_pointer_r == PTR_WD_HR);
    assign we_minute  = wr_ok && hit_th && (timer_value_pointer_r == PTR_MIN_SEC);
    assign we_second  = wr_ok && hit_tl && (timer_value_pointer_r == PTR_MIN_SEC);
    // Alarm values only through alarm windows and alarm pointer
    assign we_amonth  = wr_ok && hit_ah && (alarm_value_pointer_r == PTR_MTH_DAY);
    assign we_aday    = wr_ok && hit_al && (alarm_value_pointer_r == PTR_MTH_DAY);
    assign we_awd     = wr_ok && hit_ah && (alarm_value_pointer_r == PTR_WD_HR);
    assign we_ahr     = wr_ok && hit_al && (alarm_value_pointer_r == PTR_WD_HR);

    ////////////////////////////////////////////////////////////////////////
    // Value storage, one masked register each
    rtcv_value_reg #(.WIDTH(8), .MASK(MASK_WEEKDAY)) u_weekday (
        .clk_in   (CLK_SYS_IN),
        .rst_in   (RST_IN),
        .ce_in    (CE_IN),
        .wr_en_in (we_weekday),
        .wdata_in (ACC_WDATA_IN),
        .q_out    (TIME_VALUE_OUT.weekday)
    );
    rtcv_value_reg #(.WIDTH(8), .MASK(MASK_HOUR)) u_hour (
        .clk_in   (CLK_SYS_IN),
        .rst_in   (RST_IN),
        .ce_in    (CE_IN),
        .wr_en_in (we_hour),
        .wdata_in (ACC_WDATA_IN),
        .q_out    (TIME_VALUE_OUT.hour)
    );
    rtcv_value_reg #(.WIDTH(8), .MASK(MASK_MINUTE)) u_minute (
        .clk_in   (CLK_SYS_IN),
        .rst_in   (RST_IN),
        .ce_in    (CE_IN),
        .wr_en_in (we_minute),
        .wdata_in (ACC_WDATA_IN),
        .q_out    (TIME_VALUE_OUT.minute)
    );
    rtcv_value_reg #(.WIDTH(8), .MASK(MASK_SECOND)) u_second (
        .clk_in   (CLK_SYS_IN),
        .rst_in   (RST_IN),
        .ce_in    (CE_IN),
        .wr_en_in (we_second),
        .wdata_in (ACC_WDATA_IN),
        .q_out    (TIME_VALUE_OUT.second)
    );
    rtcv_value_reg #(.WIDTH(8), .MASK(MASK_MONTH)) u_amonth (
        .clk_in   (CLK_SYS_IN),
        .rst_in   (RST_IN),
        .ce_in    (CE_IN),
        .wr_en_in (we_amonth),
        .wdata_in (ACC_WDATA_IN),
        .q_out    (ALARM_VALUE_OUT.month)
    );
    rtcv_value_reg #(.WIDTH(8), .MASK(MASK_DAY)) u_aday (
        .clk_in   (CLK_SYS_IN),
        .rst_in   (RST_IN),
        .ce_in    (CE_IN),
        .wr_en_in (we_aday),
        .wdata_in (ACC_WDATA_IN),
        .q_out    (ALARM_VALUE_OUT.day)
    );
    rtcv_value_reg #(.WIDTH(8), .MASK(MASK_WEEKDAY)) u_awd (
        .clk_in   (CLK_SYS_IN),
        .rst_in   (RST_IN),
        .ce_in    (CE_IN),
        .wr_en_in (we_awd),
        .wdata_in (ACC_WDATA_IN),
        .q_out    (ALARM_VALUE_OUT.weekday)
    );
    rtcv_value_reg #(.WIDTH(8), .MASK(MASK_HOUR)) u_ahr (
        .clk_in   (CLK_SYS_IN),
        .rst_in   (RST_IN),
        .ce_in    (CE_IN),
        .wr_en_in (we_ahr),
        .wdata_in (ACC_WDATA_IN),
        .q_out    (ALARM_VALUE_OUT.hour)
    );

    ////////////////////////////////////////////////////////////////////////
    // Pointer next values; a high-window access steps down and sticks at 00
    // The step happens even for a locked write, since the access itself
    // is what advances the pointer, not the stored data
    always_comb begin
        timer_value_pointer_nxt = timer_value_pointer_r;
        if (acc_wr && (ACC_SEL_IN == SEL_TIMER_PTR)) begin
            timer_value_pointer_nxt = ACC_WDATA_IN[1:0];
        end else if ((acc_rd || acc_wr) && hit_th &&
                     (timer_value_pointer_r != PTR_MIN_SEC)) begin
            timer_value_pointer_nxt = timer_value_pointer_r - PTR_STEP;
        end
    end

    always_comb begin
        alarm_value_pointer_nxt = alarm_value_pointer_r;
        if (acc_wr && (ACC_SEL_IN == SEL_ALARM_CFG)) begin
            alarm_value_pointer_nxt = ACC_WDATA_IN[1:0];
        end else if ((acc_rd || acc_wr) && hit_ah &&
                     (alarm_value_pointer_r != PTR_MIN_SEC)) begin
            alarm_value_pointer_nxt = alarm_value_pointer_r - PTR_STEP;
        end
    end

    // Pointer registers
    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            timer_value_pointer_r <= PTR_RESET;
            alarm_value_pointer_r <= PTR_RESET;
        end else if (CE_IN) begin
            timer_value_pointer_r <= timer_value_pointer_nxt;
            alarm_value_pointer_r <= alarm_value_pointer_nxt;
        end
    end

    assign TIMER_PTR_OUT = timer_value_pointer_r;
    assign ALARM_PTR_OUT = alarm_value_pointer_r;

    ////////////////////////////////////////////////////////////////////////
    // Read mux: selected register before the pointer steps
    // Slots for year, month, day and alarm minute/second live elsewhere,
    // so they read as zero here
    always_comb begin
        rdata_nxt = READ_ZERO;
        unique case (ACC_SEL_IN)
            SEL_TIMER_HIGH: begin
                if (timer_value_pointer_r == PTR_WD_HR) begin
                    rdata_nxt = TIME_VALUE_OUT.weekday;
                end else if (timer_value_pointer_r == PTR_MIN_SEC) begin
                    rdata_nxt = TIME_VALUE_OUT.minute;
                end
            end
            SEL_TIMER_LOW: begin
                if (timer_value_pointer_r == PTR_WD_HR) begin
                    rdata_nxt = TIME_VALUE_OUT.hour;
                end else if (timer_value_pointer_r == PTR_MIN_SEC) begin
                    rdata_nxt = TIME_VALUE_OUT.second;
                end
            end
            SEL_ALARM_HIGH: begin
                if (alarm_value_pointer_r == PTR_MTH_DAY) begin
                    rdata_nxt = ALARM_VALUE_OUT.month;
                end else if (alarm_value_pointer_r == PTR_WD_HR) begin
                    rdata_nxt = ALARM_VALUE_OUT.weekday;
                end
            end
            SEL_ALARM_LOW: begin
                if (alarm_value_pointer_r == PTR_MTH_DAY) begin
                    rdata_nxt = ALARM_VALUE_OUT.day;
                end else if (alarm_value_pointer_r == PTR_WD_HR) begin
                    rdata_nxt = ALARM_VALUE_OUT.hour;
                end
            end
            SEL_TIMER_PTR: rdata_nxt = {6'h00, timer_value_pointer_r};
            SEL_ALARM_CFG: rdata_nxt = {6'h00, alarm_value_pointer_r};
            default:       rdata_nxt = READ_ZERO;   // Unmapped select codes
        endcase
    end

    // Read data holds until the next read
    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            ACC_RDATA_OUT <= READ_ZERO;
        end else if (acc_rd) begin
            ACC_RDATA_OUT <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (RST_IN);

    a_weekday_write: assert property (we_weekday |=>
        TIME_VALUE_OUT.weekday == ($past(ACC_WDATA_IN) & MASK_WEEKDAY))
        else $error("weekday not stored from timer high window");
    a_hour_read: assert property (acc_rd && hit_tl && TIMER_PTR_OUT == PTR_WD_HR
        |=> ACC_RDATA_OUT == $past(TIME_VALUE_OUT.hour))
        else $error("timer low at 01 did not return hour");
    a_minute_read: assert property (acc_rd && hit_th && TIMER_PTR_OUT == PTR_MIN_SEC
        |=> ACC_RDATA_OUT == $past(TIME_VALUE_OUT.minute))
        else $error("timer high at 00 did not return minute");
    a_second_write: assert property (wr_ok && hit_tl && TIMER_PTR_OUT == PTR_MIN_SEC
        |=> TIME_VALUE_OUT.second == ($past(ACC_WDATA_IN) & MASK_SECOND))
        else $error("second not stored from timer low window");
    a_amonth_read: assert property (acc_rd && hit_ah && ALARM_PTR_OUT == PTR_MTH_DAY
        |=> ACC_RDATA_OUT == $past(ALARM_VALUE_OUT.month) && ALARM_PTR_OUT == PTR_WD_HR)
        else $error("alarm high at 10 wrong data or pointer");
    a_aday_write: assert property (wr_ok && hit_al && ALARM_PTR_OUT == PTR_MTH_DAY
        |=> ALARM_VALUE_OUT.day == ($past(ACC_WDATA_IN) & MASK_DAY))
        else $error("alarm day not stored from alarm low window");
    a_awd_read: assert property (acc_rd && hit_ah && ALARM_PTR_OUT == PTR_WD_HR
        |=> ACC_RDATA_OUT == $past(ALARM_VALUE_OUT.weekday))
        else $error("alarm high at 01 did not return weekday");
    a_ahr_write: assert property (wr_ok && hit_al && ALARM_PTR_OUT == PTR_WD_HR
        |=> ALARM_VALUE_OUT.hour == ($past(ACC_WDATA_IN) & MASK_HOUR))
        else $error("alarm hour not stored from alarm low window");
    a_lock_holds_all: assert property (!WR_UNLOCK_IN |=>
        $stable(ALARM_VALUE_OUT) && $stable(TIME_VALUE_OUT))
        else $error("value changed while write lock closed");
    a_reserved_zero: assert property (
        ((TIME_VALUE_OUT.weekday & ~MASK_WEEKDAY) == 8'h00) &&
        ((TIME_VALUE_OUT.hour & ~MASK_HOUR) == 8'h00) &&
        ((TIME_VALUE_OUT.minute & ~MASK_MINUTE) == 8'h00) &&
        ((TIME_VALUE_OUT.second & ~MASK_SECOND) == 8'h00) &&
        ((ALARM_VALUE_OUT.day & ~MASK_DAY) == 8'h00) &&
        ((ALARM_VALUE_OUT.weekday & ~MASK_WEEKDAY) == 8'h00) &&
        ((ALARM_VALUE_OUT.hour & ~MASK_HOUR) == 8'h00) &&
        ((ALARM_VALUE_OUT.month & ~MASK_MONTH) == 8'h00))
        else $error("reserved value bit set");
    a_alarm_path_only: assert property (!(acc_wr && (hit_ah || hit_al)) |=>
        $stable(ALARM_VALUE_OUT))
        else $error("alarm value changed without alarm window write");
    a_aptr_step: assert property ((acc_rd || acc_wr) && hit_ah &&
        ALARM_PTR_OUT != PTR_MIN_SEC |=> ALARM_PTR_OUT == $past(ALARM_PTR_OUT) - PTR_STEP)
        else $error("alarm pointer did not step down");
    a_tptr_unimpl: assert property (acc_rd && hit_th && TIMER_PTR_OUT == PTR_NONE
        |=> TIMER_PTR_OUT == PTR_MTH_DAY ##0 ACC_RDATA_OUT == READ_ZERO)
        else $error("timer pointer 11 access wrong");
    a_tptr_floor: assert property ((acc_rd || acc_wr) && hit_th &&
        TIMER_PTR_OUT == PTR_MIN_SEC |=> TIMER_PTR_OUT == PTR_MIN_SEC)
        else $error("timer pointer went below 00");
    a_locked_discard: assert property (acc_wr && !WR_UNLOCK_IN && (hit_th || hit_tl)
        |=> $stable(TIME_VALUE_OUT))
        else $error("locked timer write changed a value");

    c_walk_timer: cover property (acc_rd && hit_th && TIMER_PTR_OUT == PTR_NONE
        ##1 acc_rd && hit_th [*3]);
    c_alarm_write: cover property (we_amonth ##[1:4] we_awd);
    c_locked_write: cover property (acc_wr && !WR_UNLOCK_IN && hit_tl);
    // Read and write on one select in one cycle, read sees the old value
    c_rw_same: cover property (acc_rd && acc_wr && hit_tl);
    c_alarm_floor: cover property (acc_rd && hit_ah && ALARM_PTR_OUT == PTR_MIN_SEC);

endmodule : rtcv_top

// [common/rtcv_pkg.sv]
// Package with codes, masks and value layouts of the clock value windows
package rtcv_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Access select codes on the register port
    localparam logic [2:0] SEL_TIMER_HIGH = 3'h0;   // Timer high window
    localparam logic [2:0] SEL_TIMER_LOW  = 3'h1;   // Timer low window
    localparam logic [2:0] SEL_ALARM_HIGH = 3'h2;   // Alarm high window
    localparam logic [2:0] SEL_ALARM_LOW  = 3'h3;   // Alarm low window
    localparam logic [2:0] SEL_TIMER_PTR  = 3'h4;   // Timer pointer field
    localparam logic [2:0] SEL_ALARM_CFG  = 3'h5;   // Alarm config, pointer field

    ////////////////////////////////////////////////////////////////////////
    // Pointer values shared by timer and alarm windows
    localparam logic [1:0] PTR_MIN_SEC  = 2'h0;     // Minute / second
    localparam logic [1:0] PTR_WD_HR    = 2'h1;     // Weekday / hour
    localparam logic [1:0] PTR_MTH_DAY  = 2'h2;     // Month / day
    localparam logic [1:0] PTR_NONE     = 2'h3;     // Nothing here
    localparam logic [1:0] PTR_STEP     = 2'h1;     // Decrement step
    localparam logic [1:0] PTR_RESET    = 2'h0;     // Pointer after reset

    ////////////////////////////////////////////////////////////////////////
    // Implemented bits of each value register
    localparam logic [7:0] MASK_WEEKDAY = 8'h07;    // Weekday digit, bits 2-0
    localparam logic [7:0] MASK_HOUR    = 8'h3F;    // Tens 5-4, ones 3-0
    localparam logic [7:0] MASK_MINUTE  = 8'h7F;    // Tens 6-4, ones 3-0
    localparam logic [7:0] MASK_SECOND  = 8'h7F;    // Tens 6-4, ones 3-0
    localparam logic [7:0] MASK_MONTH   = 8'h1F;    // Tens bit 4, ones 3-0
    localparam logic [7:0] MASK_DAY     = 8'h3F;    // Tens 5-4, ones 3-0
    localparam logic [7:0] MASK_PTR     = 8'h03;    // Pointer field bits 1-0
    localparam logic [7:0] VALUE_RESET  = 8'h00;    // Value after reset
    localparam logic [7:0] READ_ZERO    = 8'h00;    // Unimplemented read

    ////////////////////////////////////////////////////////////////////////
    // Value carriers
    typedef struct packed {
        logic [7:0] weekday;                        // Weekday digit
        logic [7:0] hour;                           // Hour digits
        logic [7:0] minute;                         // Minute digits
        logic [7:0] second;                         // Second digits
    } rtcv_time_s;

    typedef struct packed {
        logic [7:0] month;                          // Alarm month digits
        logic [7:0] day;                            // Alarm day digits
        logic [7:0] weekday;                        // Alarm weekday digit
        logic [7:0] hour;                           // Alarm hour digits
    } rtcv_alarm_s;

endpackage : rtcv_pkg

// [src/rtcv_value_reg.sv]
// One masked BCD value register with write enable
module rtcv_value_reg
    import rtcv_pkg::*;
#(
    parameter int         WIDTH = 8,                // Register width
    parameter logic [7:0] MASK  = 8'hFF             // Implemented bits
) (
    input  wire logic             clk_in,           // System clock
    input  wire logic             rst_in,           // Async reset, high
    input  wire logic             ce_in,            // Clock enable
    input  wire logic             wr_en_in,         // Accepted write
    input  wire logic [WIDTH-1:0] wdata_in,         // Write data
    output logic      [WIDTH-1:0] q_out             // Stored value
);

    ////////////////////////////////////////////////////////////////////////
    // Storage; bits outside the mask never hold a one, so reads see zero
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            q_out <= VALUE_RESET[WIDTH-1:0];
        end else if (ce_in && wr_en_in) begin
            q_out <= wdata_in & MASK[WIDTH-1:0];
        end
    end

endmodule : rtcv_value_reg

// [testbench/rtcv_top_tb_top.sv]
// Self-checking bench for the timer and alarm value windows
module rtcv_top_tb_top
    import rtcv_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    ////////////////////////////////////////////////////////////////////////
    // Stimulus and observation signals
    logic        clk_sys;                           // 40 MHz clock
    logic        rst;                               // Async reset, high
    logic        ce;                                // Clock enable
    logic        unlock;                            // Write unlock level
    logic [2:0]  sel;                               // Register select
    logic        rd;                                // Read strobe
    logic        wr;                                // Write strobe
    logic [7:0]  wdata;                             // Write data
    logic [7:0]  rdata;                             // Read data
    logic [1:0]  tptr;                              // Timer pointer
    logic [1:0]  aptr;                              // Alarm pointer
    rtcv_time_s  tval;                              // Timer values
    rtcv_alarm_s aval;                              // Alarm values
    int          failures;                          // Mismatch count
    int          checks_done;                       // Compare count

    ////////////////////////////////////////////////////////////////////////
    // Device under test, every input driven by the bench
    rtcv_top dut_u (
        .CLK_SYS_IN      (clk_sys),
        .RST_IN          (rst),
        .CE_IN           (ce),
        .WR_UNLOCK_IN    (unlock),
        .ACC_SEL_IN      (sel),
        .ACC_RD_IN       (rd),
        .ACC_WR_IN       (wr),
        .ACC_WDATA_IN    (wdata),
        .ACC_RDATA_OUT   (rdata),
        .TIMER_PTR_OUT   (tptr),
        .ALARM_PTR_OUT   (aptr),
        .TIME_VALUE_OUT  (tval),
        .ALARM_VALUE_OUT (aval)
    );

    // Free-running clock, 25 ns period
    always #12.5 clk_sys = ~clk_sys;

    ////////////////////////////////////////////////////////////////////////
    // Shared tasks
    // Compare one value, four-state exact
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // One access: strobe held for exactly one rising edge, launched at falling edge
    task automatic acc(input logic [2:0] s, input logic r, input logic w, input logic [7:0] d);
        @(negedge clk_sys);
        sel   = s;
        rd    = r;
        wr    = w;
        wdata = d;
        @(negedge clk_sys);
        rd    = 1'b0;
        wr    = 1'b0;
    endtask : acc

    // Write access
    task automatic wr_acc(input logic [2:0] s, input logic [7:0] d);
        acc(s, 1'b0, 1'b1, d);
    endtask : wr_acc

    // Read access, data settled one edge later, compared at falling edge
    task automatic rd_chk(input string what, input logic [2:0] s, input logic [7:0] exp);
        acc(s, 1'b1, 1'b0, 8'h00);
        check(what, rdata, exp);
    endtask : rd_chk

    // Closing report, the only place the run ends
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict

    ////////////////////////////////////////////////////////////////////////
    // Watchdog: run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk_sys);
        failures++;
        print_verdict();
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        clk_sys = 1'b0; rst = 1'b1; ce = 1'b1; unlock = 1'b1;
        sel = 3'h0; rd = 1'b0; wr = 1'b0; wdata = 8'h00;
        failures = 0; checks_done = 0;
        repeat (10) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        check("timer ptr reset", {6'h00, tptr}, {6'h00, PTR_RESET});
        // Timer writes in pointer order; all-ones shows reserved bits dropped
        wr_acc(SEL_TIMER_PTR, 8'hFD);               // Upper bits ignored, field 01
        check("timer ptr set", {6'h00, tptr}, {6'h00, PTR_WD_HR});
        wr_acc(SEL_TIMER_LOW, 8'hFF);
        check("hour", tval.hour, 8'hFF & MASK_HOUR);
        check("ptr no step low", {6'h00, tptr}, {6'h00, PTR_WD_HR});
        wr_acc(SEL_TIMER_HIGH, 8'hFE);
        check("weekday", tval.weekday, 8'h06);
        check("ptr step", {6'h00, tptr}, {6'h00, PTR_MIN_SEC});
        wr_acc(SEL_TIMER_LOW, 8'hD9);
        check("second", tval.second, 8'h59);
        wr_acc(SEL_TIMER_HIGH, 8'hA3);
        check("minute", tval.minute, 8'h23);
        check("ptr stop", {6'h00, tptr}, {6'h00, PTR_MIN_SEC});
        // Read back through the windows
        wr_acc(SEL_TIMER_PTR, 8'h01);
        rd_chk("rd hour", SEL_TIMER_LOW, 8'h3F);
        rd_chk("rd weekday", SEL_TIMER_HIGH, 8'h06);
        rd_chk("rd second", SEL_TIMER_LOW, 8'h59);
        rd_chk("rd minute", SEL_TIMER_HIGH, 8'h23);
        // Read and write together: read returns the old second
        acc(SEL_TIMER_LOW, 1'b1, 1'b1, 8'hC5);
        check("rw old second", rdata, 8'h59);
        check("rw new second", tval.second, 8'h45);
        // Empty slot 11 still steps the pointer
        wr_acc(SEL_TIMER_PTR, 8'h03);
        rd_chk("rd empty", SEL_TIMER_HIGH, READ_ZERO);
        check("ptr from 11", {6'h00, tptr}, {6'h00, PTR_MTH_DAY});
        rd_chk("rd timer ptr", SEL_TIMER_PTR, 8'h02);
        // Alarm values only through alarm windows, in pointer order
        wr_acc(SEL_ALARM_CFG, 8'h02);
        rd_chk("rd alarm cfg", SEL_ALARM_CFG, 8'h02);
        wr_acc(SEL_ALARM_LOW, 8'hFF);
        check("alarm day", aval.day, 8'hFF & MASK_DAY);
        wr_acc(SEL_ALARM_HIGH, 8'hF2);
        check("alarm month", aval.month, 8'h12);
        check("alarm ptr step", {6'h00, aptr}, {6'h00, PTR_WD_HR});
        wr_acc(SEL_ALARM_LOW, 8'hE3);
        check("alarm hour", aval.hour, 8'h23);
        wr_acc(SEL_ALARM_HIGH, 8'hFD);
        check("alarm wd", aval.weekday, 8'h05);
        check("alarm ptr 00", {6'h00, aptr}, {6'h00, PTR_MIN_SEC});
        rd_chk("rd alarm 00", SEL_ALARM_HIGH, READ_ZERO);
        check("alarm ptr hold", {6'h00, aptr}, {6'h00, PTR_MIN_SEC});
        check("timer untouched", tval.hour, 8'h3F);
        wr_acc(SEL_ALARM_CFG, 8'h02);
        rd_chk("rd alarm day", SEL_ALARM_LOW, 8'h3F);
        rd_chk("rd alarm month", SEL_ALARM_HIGH, 8'h12);
        rd_chk("rd alarm hour", SEL_ALARM_LOW, 8'h23);
        rd_chk("rd alarm wd", SEL_ALARM_HIGH, 8'h05);
        // Locked writes are dropped, pointer still steps
        unlock = 1'b0;
        wr_acc(SEL_TIMER_PTR, 8'h01);
        wr_acc(SEL_TIMER_LOW, 8'h12);
        check("locked hour", tval.hour, 8'h3F);
        wr_acc(SEL_TIMER_HIGH, 8'h03);
        check("locked weekday", tval.weekday, 8'h06);
        check("locked ptr step", {6'h00, tptr}, {6'h00, PTR_MIN_SEC});
        wr_acc(SEL_TIMER_LOW, 8'h11);
        check("locked second", tval.second, 8'h45);
        wr_acc(SEL_ALARM_CFG, 8'h02);
        wr_acc(SEL_ALARM_LOW, 8'h01);
        check("locked alarm day", aval.day, 8'h3F);
        wr_acc(SEL_ALARM_HIGH, 8'h01);
        check("locked alarm month", aval.month, 8'h12);
        // Clock enable low freezes state; unmapped select reads zero
        ce = 1'b0;
        wr_acc(SEL_TIMER_PTR, 8'h02);
        check("ce frozen", {6'h00, tptr}, {6'h00, PTR_MIN_SEC});
        ce = 1'b1;
        rd_chk("rd unmapped", 3'h6, READ_ZERO);
        print_verdict();
    end

endmodule : rtcv_top_tb_top
